//--- hw/mmu_pkg.sv
// shared constants, types and helpers for the address translation unit
package mmu_pkg;
  // address geometry
  localparam int VA_W = 32; // virtual address width
  localparam int PA_W = 32; // physical address width, full 4 GB
  localparam int OFFSET_W = 12; // 4 KB page offset
  localparam int VPI_W = 20; // virtual page index width
  localparam int PFI_W = 20; // physical frame index width
  localparam int PART_LSB = 29; // partition field is va[31:29]
  localparam int PART_W = 3; // width of the partition field
  localparam int BYPASS_W = 29; // low memory bits kept on bypass
  // tlb defaults
  localparam int TAG_W = 8; // process tag width (8 to 14)
  localparam int TLB_ENTRIES = 16; // number of entries
  // reset pages point into the peripheral partition, which never hits
  localparam logic [VPI_W-1:0] INVALID_VPI_BASE = 20'hE0000;
  // access kinds
  localparam int ACC_W = 2;
  localparam logic [ACC_W-1:0] ACC_FETCH = 2'h0; // instruction fetch
  localparam logic [ACC_W-1:0] ACC_LOAD = 2'h1; // data load
  localparam logic [ACC_W-1:0] ACC_STORE = 2'h2; // data store
  localparam logic [ACC_W-1:0] ACC_FLUSH = 2'h3; // data cache flush
  // exception codes
  localparam int EXC_W = 3;
  localparam logic [EXC_W-1:0] EXC_NONE = 3'h0;
  localparam logic [EXC_W-1:0] EXC_FAST_MISS = 3'h1;
  localparam logic [EXC_W-1:0] EXC_DOUBLE_MISS = 3'h2;
  localparam logic [EXC_W-1:0] EXC_PERM = 3'h3;
  localparam logic [EXC_W-1:0] EXC_SUPV_ONLY = 3'h4;
  // partitions of the virtual space
  typedef enum logic [1:0] {
    PART_USER = 2'b00,
    PART_SUPV = 2'b01,
    PART_KERNEL = 2'b10,
    PART_IO = 2'b11
  } partition_e;

  // top three address bits to partition
  function automatic partition_e decode_partition(
    input logic [PART_W-1:0] top
  );
    case (top)
      3'h7: decode_partition = PART_IO;
      3'h6: decode_partition = PART_KERNEL;
      3'h5, 3'h4: decode_partition = PART_SUPV;
      default: decode_partition = PART_USER;
    endcase
  endfunction : decode_partition
endpackage : mmu_pkg

//--- hw/mmu_partition_decode.sv
// partition decode, bypass address and partition default cacheability
`timescale 1ns/1ps
`default_nettype none
module mmu_partition_decode (
  input wire logic [mmu_pkg::VA_W-1:0] vaddr,
  output mmu_pkg::partition_e part,
  output logic bypass,
  output logic supv_only,
  output logic default_cached,
  output logic [mmu_pkg::PA_W-1:0] bypass_paddr
);
  // partition from the top three bits only
  assign part = mmu_pkg::decode_partition(
    vaddr[mmu_pkg::VA_W-1:mmu_pkg::PART_LSB]); // R9 R10 R11 R12
  // peripheral and kernel partitions skip the tlb
  assign bypass = (part == mmu_pkg::PART_IO) ||
                  (part == mmu_pkg::PART_KERNEL); // R9 R10
  // everything but the user partition is supervisor only
  assign supv_only = (part != mmu_pkg::PART_USER); // R13
  // only the kernel partition defaults to cached; bit 31 plays no part
  assign default_cached = (part == mmu_pkg::PART_KERNEL); // R17 R9 R10
  // bypass clears the top three bits, reaching low memory only
  assign bypass_paddr = {{(mmu_pkg::PA_W-mmu_pkg::BYPASS_W){1'b0}},
                         vaddr[mmu_pkg::BYPASS_W-1:0]}; // R14 R15
endmodule : mmu_partition_decode
`default_nettype wire

//--- hw/mmu_tlb.sv
// software-managed tlb store with a single-cycle lookup
`timescale 1ns/1ps
`default_nettype none
module mmu_tlb #(
  parameter int ENTRIES = mmu_pkg::TLB_ENTRIES,
  parameter int TAG_W = mmu_pkg::TAG_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [$clog2(ENTRIES)-1:0] wr_index,
  input wire logic [mmu_pkg::VPI_W-1:0] wr_vpi,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic wr_global,
  input wire logic [mmu_pkg::PFI_W-1:0] wr_pfi,
  input wire logic wr_cached,
  input wire logic wr_read,
  input wire logic wr_write,
  input wire logic wr_exec,
  input wire logic [mmu_pkg::VPI_W-1:0] lk_vpi,
  input wire logic [TAG_W-1:0] lk_tag,
  output logic hit,
  output logic [mmu_pkg::PFI_W-1:0] hit_pfi,
  output logic hit_cached,
  output logic hit_read,
  output logic hit_write,
  output logic hit_exec
);
  logic [mmu_pkg::VPI_W-1:0] vpi_q [ENTRIES]; // page index per entry
  logic [TAG_W-1:0] tag_q [ENTRIES]; // owning process tag
  logic [ENTRIES-1:0] global_q; // tag ignored when set
  logic [mmu_pkg::PFI_W-1:0] pfi_q [ENTRIES]; // frame index
  logic [ENTRIES-1:0] cached_q, read_q, write_q, exec_q; // page flags

  // entries change only on a software write, never by a table walk
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < ENTRIES; i++) begin
        // distinct peripheral pages stand in for a missing valid bit
        vpi_q[i] <= mmu_pkg::INVALID_VPI_BASE | mmu_pkg::VPI_W'(i);
        tag_q[i] <= '0;
        pfi_q[i] <= '0;
      end
      global_q <= '0;
      cached_q <= '0;
      read_q <= '0;
      write_q <= '0;
      exec_q <= '0;
    end else if (wr_en) begin // R5
      vpi_q[wr_index] <= wr_vpi;
      tag_q[wr_index] <= wr_tag;
      pfi_q[wr_index] <= wr_pfi;
      global_q[wr_index] <= wr_global;
      cached_q[wr_index] <= wr_cached;
      read_q[wr_index] <= wr_read;
      write_q[wr_index] <= wr_write;
      exec_q[wr_index] <= wr_exec;
    end
  end

  // key is page index plus process tag; lowest matching index wins
  // since duplicate mappings are software's fault and undefined anyway
  always_comb begin
    hit = 1'b0;
    hit_pfi = '0;
    hit_cached = 1'b0;
    hit_read = 1'b0;
    hit_write = 1'b0;
    hit_exec = 1'b0;
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (vpi_q[i] == lk_vpi &&
          (global_q[i] || tag_q[i] == lk_tag)) begin // R3
        hit = 1'b1;
        hit_pfi = pfi_q[i];
        hit_cached = cached_q[i]; // R8
        hit_read = read_q[i]; // R6
        hit_write = write_q[i];
        hit_exec = exec_q[i];
      end
    end
  end
endmodule : mmu_tlb
`default_nettype wire

//--- hw/mmu_address_translation.sv
// address translation and protection front end of the mmu
//
// How it works
// R1 - translate in 4 KB pages only
// R2 - split address into page index, offset
// R3 - lookup by page index and process tag
// R4 - physical address is frame plus offset
// R5 - tlb changes only by software writes
// R6 - each entry carries read write execute bits
// R7 - miss or denial raises precise exception
// R8 - mapped pages take cacheability from entry
// R9 - peripheral partition bypasses, supervisor, uncached
// R10 - kernel partition bypasses, supervisor, cached
// R11 - supervisor partition translates, supervisor only
// R12 - user partition translates, tlb decides rest
// R13 - user mode denied outside user partition
// R14 - bypass clears top three address bits
// R15 - high memory reachable only through tlb
// R16 - uncached data goes straight to interconnect
// R17 - bit 31 never selects cacheability
// R18 - peripheral loads stores always uncached
// R19 - vectors must lie in low memory
// R20 - full 4 GB virtual and physical
// R21 - miss with handler active is double miss
// R22 - load needs read, store write, fetch exec
// R23 - decode partition alongside lookup, same cycle
`timescale 1ns/1ps
`default_nettype none
module mmu_address_translation #(
  parameter int TLB_ENTRIES = mmu_pkg::TLB_ENTRIES,
  parameter int TAG_W = mmu_pkg::TAG_W
) (
  input wire logic clk,
  input wire logic srst,
  // request from the pipeline
  input wire logic req_valid,
  input wire logic [mmu_pkg::VA_W-1:0] req_vaddr,
  input wire logic [mmu_pkg::ACC_W-1:0] req_access,
  input wire logic req_io_op,
  // processor state
  input wire logic user_mode,
  input wire logic [TAG_W-1:0] process_tag,
  input wire logic exception_handler_active,
  // software tlb write port
  input wire logic tlb_wr_en,
  input wire logic [$clog2(TLB_ENTRIES)-1:0] tlb_wr_index,
  input wire logic [mmu_pkg::VPI_W-1:0] tlb_wr_vpi,
  input wire logic [TAG_W-1:0] tlb_wr_tag,
  input wire logic tlb_wr_global,
  input wire logic [mmu_pkg::PFI_W-1:0] tlb_wr_pfi,
  input wire logic tlb_wr_cached,
  input wire logic tlb_wr_read,
  input wire logic tlb_wr_write,
  input wire logic tlb_wr_exec,
  // answer towards the interconnect
  output logic rsp_valid,
  output logic [mmu_pkg::PA_W-1:0] rsp_paddr,
  output logic [mmu_pkg::EXC_W-1:0] rsp_exc,
  output logic rsp_cached,
  output logic rsp_direct,
  output logic [mmu_pkg::VPI_W-1:0] rsp_fault_vpi
);
  // request fields
  logic [mmu_pkg::VPI_W-1:0] vpi; // page index
  logic [mmu_pkg::OFFSET_W-1:0] offset; // untranslated offset
  // partition decode outputs
  mmu_pkg::partition_e part;
  logic bypass, supv_only, default_cached;
  logic [mmu_pkg::PA_W-1:0] bypass_paddr;
  // tlb lookup outputs
  logic tlb_hit, hit_cached, hit_read, hit_write, hit_exec;
  logic [mmu_pkg::PFI_W-1:0] hit_pfi;
  // combinational decisions
  logic denied; // supervisor-only partition reached from user
  logic perm_ok; // entry grants this kind of access
  logic is_data; // load, store or flush
  // next values of the answer
  logic [mmu_pkg::PA_W-1:0] paddr_d;
  logic [mmu_pkg::EXC_W-1:0] exc_d;
  logic cached_d, direct_d;
  // answer registers
  logic rsp_valid_q, rsp_cached_q, rsp_direct_q;
  logic [mmu_pkg::PA_W-1:0] rsp_paddr_q;
  logic [mmu_pkg::EXC_W-1:0] rsp_exc_q;
  logic [mmu_pkg::VPI_W-1:0] rsp_fault_vpi_q;

  // page granular split, offset bits pass untouched
  assign vpi = req_vaddr[mmu_pkg::VA_W-1:mmu_pkg::OFFSET_W]; // R1 R2
  assign offset = req_vaddr[mmu_pkg::OFFSET_W-1:0]; // R2
  assign is_data = (req_access != mmu_pkg::ACC_FETCH);

  // partition decode runs beside the lookup in the same cycle
  mmu_partition_decode u_decode (
    .vaddr(req_vaddr),
    .part(part),
    .bypass(bypass),
    .supv_only(supv_only),
    .default_cached(default_cached),
    .bypass_paddr(bypass_paddr)
  ); // R23

  // tlb storage; looked up on every cycle, used only when translating
  mmu_tlb #(
    .ENTRIES(TLB_ENTRIES),
    .TAG_W(TAG_W)
  ) u_tlb (
    .clk(clk),
    .srst(srst),
    .wr_en(tlb_wr_en),
    .wr_index(tlb_wr_index),
    .wr_vpi(tlb_wr_vpi),
    .wr_tag(tlb_wr_tag),
    .wr_global(tlb_wr_global),
    .wr_pfi(tlb_wr_pfi),
    .wr_cached(tlb_wr_cached),
    .wr_read(tlb_wr_read),
    .wr_write(tlb_wr_write),
    .wr_exec(tlb_wr_exec),
    .lk_vpi(vpi),
    .lk_tag(process_tag),
    .hit(tlb_hit),
    .hit_pfi(hit_pfi),
    .hit_cached(hit_cached),
    .hit_read(hit_read),
    .hit_write(hit_write),
    .hit_exec(hit_exec)
  ); // R3 R6

  // user mode may only touch the user partition
  assign denied = user_mode && supv_only; // R13

  // permission per access kind; a flush needs no page permission
  always_comb begin
    case (req_access)
      mmu_pkg::ACC_FETCH: perm_ok = hit_exec; // R22
      mmu_pkg::ACC_LOAD: perm_ok = hit_read; // R22
      mmu_pkg::ACC_STORE: perm_ok = hit_write; // R22
      default: perm_ok = 1'b1; // flush
    endcase
  end

  // exception priority: mode denial, then miss, then permission
  always_comb begin
    if (denied) begin
      exc_d = mmu_pkg::EXC_SUPV_ONLY; // R13 R9 R10 R11
    end else if (!bypass && !tlb_hit) begin
      // nested miss inside the handler gets its own code
      exc_d = exception_handler_active ? mmu_pkg::EXC_DOUBLE_MISS
                                       : mmu_pkg::EXC_FAST_MISS; // R21 R7
    end else if (!bypass && !perm_ok) begin
      exc_d = mmu_pkg::EXC_PERM; // R7 R22
    end else begin
      exc_d = mmu_pkg::EXC_NONE;
    end
  end

  // address: frame and offset when mapped, cleared top bits on bypass;
  // high frames only come out of the tlb path
  assign paddr_d = bypass ? bypass_paddr
                          : {hit_pfi, offset}; // R4 R14 R15 R20

  // cacheability from partition or entry, peripheral ops override
  assign cached_d = (bypass ? default_cached : hit_cached) &&
                    !req_io_op; // R8 R17 R18
  // uncached data skips the data cache
  assign direct_d = is_data && !cached_d &&
                    (exc_d == mmu_pkg::EXC_NONE); // R16

  // answer valid one cycle after each request
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
    end else begin
      rsp_valid_q <= req_valid; // R23
    end
  end

  // address and attributes; held between requests
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_paddr_q <= '0;
      rsp_cached_q <= 1'b0;
      rsp_direct_q <= 1'b0;
    end else if (req_valid) begin
      // a faulting access carries no usable address
      rsp_paddr_q <= (exc_d == mmu_pkg::EXC_NONE) ? paddr_d : '0; // R4
      rsp_cached_q <= cached_d && (exc_d == mmu_pkg::EXC_NONE); // R8
      rsp_direct_q <= direct_d; // R16
    end
  end

  // exception code and faulting page, kept for the refill handler
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_exc_q <= mmu_pkg::EXC_NONE;
      rsp_fault_vpi_q <= '0;
    end else if (req_valid) begin
      rsp_exc_q <= exc_d; // R7
      if (exc_d != mmu_pkg::EXC_NONE) begin
        rsp_fault_vpi_q <= vpi; // R7
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_paddr = rsp_paddr_q;
  assign rsp_exc = rsp_exc_q;
  assign rsp_cached = rsp_cached_q;
  assign rsp_direct = rsp_direct_q;
  assign rsp_fault_vpi = rsp_fault_vpi_q;

  // checks on the answer stage
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // a mapped access that hits with the needed right
  sequence s_xlate_ok;
    req_valid && !bypass && !denied && tlb_hit && perm_ok;
  endsequence
  // a mapped access with no matching entry
  sequence s_miss;
    req_valid && !bypass && !denied && !tlb_hit;
  endsequence
  // any access not denied to the mode, into a partition that skips the tlb
  sequence s_bypass;
    req_valid && bypass && !denied;
  endsequence
  // a data access into a partition that skips the tlb
  sequence s_bypass_data;
    req_valid && bypass && !denied && is_data;
  endsequence
  // a mapped access that hits but lacks the right
  sequence s_perm_fault;
    req_valid && !bypass && !denied && tlb_hit && !perm_ok;
  endsequence

  a_answer_latency: assert property ( // R23
    req_valid |=> rsp_valid ##1 (rsp_valid == $past(req_valid)))
    else $error("answer not one cycle after request");
  a_frame_offset: assert property (s_xlate_ok |=> // R4
    rsp_paddr == {$past(hit_pfi), $past(offset)} &&
    rsp_exc == mmu_pkg::EXC_NONE)
    else $error("translated address wrong");
  a_bypass_clear: assert property (s_bypass |=> // R14
    rsp_paddr[mmu_pkg::PA_W-1:mmu_pkg::BYPASS_W] == '0 &&
    rsp_paddr[mmu_pkg::BYPASS_W-1:0] ==
      $past(req_vaddr[mmu_pkg::BYPASS_W-1:0]))
    else $error("bypass address wrong");
  a_user_denied: assert property ( // R13
    req_valid && user_mode && req_vaddr[mmu_pkg::VA_W-1] |=>
    rsp_exc == mmu_pkg::EXC_SUPV_ONLY)
    else $error("user access to supervisor space passed");
  a_miss_kind: assert property (s_miss |=> // R21
    rsp_exc == ($past(exception_handler_active) ?
      mmu_pkg::EXC_DOUBLE_MISS : mmu_pkg::EXC_FAST_MISS) &&
    rsp_fault_vpi == $past(vpi))
    else $error("miss code or fault page wrong");
  a_store_perm: assert property ( // R22
    req_valid && !bypass && !denied && tlb_hit &&
    req_access == mmu_pkg::ACC_STORE && !hit_write |=>
    rsp_exc == mmu_pkg::EXC_PERM)
    else $error("store to read only page passed");
  a_load_perm: assert property ( // R22
    req_valid && !bypass && !denied && tlb_hit &&
    req_access == mmu_pkg::ACC_LOAD && !hit_read |=>
    rsp_exc == mmu_pkg::EXC_PERM)
    else $error("load from unreadable page passed");
  a_fetch_perm: assert property ( // R22
    req_valid && !bypass && !denied && tlb_hit &&
    req_access == mmu_pkg::ACC_FETCH && !hit_exec |=>
    rsp_exc == mmu_pkg::EXC_PERM)
    else $error("fetch from non executable page passed");
  a_perm_fault: assert property (s_perm_fault |=> // R7
    rsp_exc == mmu_pkg::EXC_PERM && rsp_fault_vpi == $past(vpi))
    else $error("permission fault or fault page wrong");
  a_io_op_uncached: assert property ( // R18
    req_valid && req_io_op |=> !rsp_cached)
    else $error("peripheral op marked cached");
  // bypass data answers go to the fabric exactly when uncached
  a_part_default: assert property (s_bypass_data |=> // R9 R10
    rsp_cached == ($past(part) == mmu_pkg::PART_KERNEL &&
                   !$past(req_io_op)) &&
    rsp_direct == !rsp_cached)
    else $error("partition default cacheability wrong");
  a_io_uncached: assert property ( // R9
    req_valid && !denied && part == mmu_pkg::PART_IO |=> !rsp_cached)
    else $error("peripheral partition marked cached");
  a_kernel_cached: assert property ( // R10
    req_valid && !denied && part == mmu_pkg::PART_KERNEL && !req_io_op
    |=> rsp_cached)
    else $error("kernel partition not cached");
  a_entry_cached: assert property (s_xlate_ok |=> // R8
    rsp_cached == ($past(hit_cached) && !$past(req_io_op)))
    else $error("page cacheability not from entry");
  a_fetch_direct: assert property ( // R16
    req_valid && req_access == mmu_pkg::ACC_FETCH |=> !rsp_direct)
    else $error("fetch sent straight to the fabric");
  // the refill handler relies on the fault page surviving clean answers
  a_fault_vpi_hold: assert property ( // R7
    rsp_valid && rsp_exc == mmu_pkg::EXC_NONE |-> $stable(rsp_fault_vpi))
    else $error("fault page changed without a fault");
  a_fault_quiet: assert property ( // R7
    rsp_valid && rsp_exc != mmu_pkg::EXC_NONE |->
    !rsp_cached && !rsp_direct && rsp_paddr == '0)
    else $error("faulting access still issued");
endmodule : mmu_address_translation
`default_nettype wire

//--- bench/mmu_interconnect_model.sv
// interconnect side model: counts data traffic that skips the cache
`timescale 1ns/1ps
`default_nettype none
module mmu_interconnect_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic rsp_valid,
  input wire logic rsp_direct,
  output logic [31:0] direct_cnt,
  output logic [31:0] vec_base
);
  // vectors kept in low memory so the kernel alias can reach them
  assign vec_base = 32'h00000120;
  // count accesses routed straight to the fabric
  always_ff @(posedge clk) begin
    if (srst) begin
      direct_cnt <= 32'h0;
    end else if (rsp_valid && rsp_direct) begin
      direct_cnt <= direct_cnt + 32'h1;
    end
  end
endmodule : mmu_interconnect_model
`default_nettype wire

//--- bench/test_mmu_address_translation.sv
// self-checking bench for the address translation front end
`timescale 1ns/1ps
`default_nettype none
module test_mmu_address_translation;
  // one expected answer
  typedef struct packed {
    logic [31:0] paddr;
    logic [2:0] exc;
    logic cached;
    logic direct;
    logic [19:0] fvpi;
  } exp_s;
  logic clk, srst, req_valid, req_io_op, user_mode;
  logic exception_handler_active, tlb_wr_en, tlb_wr_global;
  logic tlb_wr_cached, tlb_wr_read, tlb_wr_write, tlb_wr_exec;
  logic rsp_valid, rsp_cached, rsp_direct;
  logic [31:0] req_vaddr, rsp_paddr, direct_cnt, vec_base, va;
  logic [1:0] req_access;
  logic [7:0] process_tag, tlb_wr_tag;
  logic [3:0] tlb_wr_index;
  logic [19:0] tlb_wr_vpi, tlb_wr_pfi, rsp_fault_vpi, last_fvpi;
  logic [2:0] rsp_exc;
  // bench copy of the tlb; flags are cached, read, write, exec
  logic [19:0] m_vpi [16];
  logic [19:0] m_pfi [16];
  logic [7:0] m_tag [16];
  logic [3:0] m_fl [16];
  logic m_g [16];
  exp_s q[$];
  int errors, checks, seed, n_direct;
  mmu_address_translation dut (
    .clk, .srst, .req_valid, .req_vaddr, .req_access, .req_io_op,
    .user_mode, .process_tag, .exception_handler_active,
    .tlb_wr_en, .tlb_wr_index, .tlb_wr_vpi, .tlb_wr_tag, .tlb_wr_global,
    .tlb_wr_pfi, .tlb_wr_cached, .tlb_wr_read, .tlb_wr_write,
    .tlb_wr_exec, .rsp_valid, .rsp_paddr, .rsp_exc, .rsp_cached,
    .rsp_direct, .rsp_fault_vpi
  );
  mmu_interconnect_model far (
    .clk, .srst, .rsp_valid, .rsp_direct, .direct_cnt, .vec_base
  );
  // expected answer, lowest matching index wins
  function automatic exp_s calc(logic [31:0] a, logic [1:0] acc,
    logic io, logic u);
    exp_s e;
    int h;
    logic ok;
    e = '0;
    h = -1;
    for (int i = 15; i >= 0; i--) begin
      if (m_vpi[i] == a[31:12] && (m_g[i] || m_tag[i] == process_tag))
        h = i;
    end
    if (u && a[31]) e.exc = 3'h4;
    else if (a[31:30] == 2'b11) begin
      e.paddr = {3'h0, a[28:0]};
      e.cached = !a[29];
    end else if (h < 0) e.exc = exception_handler_active ? 3'h2 : 3'h1;
    else begin
      ok = acc == 2'h0 ? m_fl[h][0] : acc == 2'h1 ? m_fl[h][2] :
        acc == 2'h2 ? m_fl[h][1] : 1'b1;
      if (!ok) e.exc = 3'h3;
      else begin
        e.paddr = {m_pfi[h], a[11:0]};
        e.cached = m_fl[h][3];
      end
    end
    if (io) e.cached = 1'b0;
    if (e.exc != 3'h0) begin
      e.cached = 1'b0;
      e.paddr = '0;
      last_fvpi = a[31:12];
    end
    e.direct = e.exc == 3'h0 && acc != 2'h0 && !e.cached;
    e.fvpi = last_fvpi;
    return e;
  endfunction : calc
  task automatic check(string n, logic [31:0] s, logic [31:0] x);
    checks++;
    if (s !== x) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : check
  task automatic req(logic [31:0] a, logic [1:0] acc, logic io,
    logic u);
    @(posedge clk);
    tlb_wr_en <= 1'b0;
    req_valid <= 1'b1;
    req_vaddr <= a;
    req_access <= acc;
    req_io_op <= io;
    user_mode <= u;
    q.push_back(calc(a, acc, io, u));
  endtask : req
  task automatic wr(int i, logic [19:0] v, logic [7:0] t, logic g,
    logic [19:0] p, logic [3:0] f);
    @(posedge clk);
    req_valid <= 1'b0;
    tlb_wr_en <= 1'b1;
    tlb_wr_index <= i[3:0];
    tlb_wr_vpi <= v;
    tlb_wr_tag <= t;
    tlb_wr_global <= g;
    tlb_wr_pfi <= p;
    {tlb_wr_cached, tlb_wr_read, tlb_wr_write, tlb_wr_exec} <= f;
    m_vpi[i] = v;
    m_tag[i] = t;
    m_g[i] = g;
    m_pfi[i] = p;
    m_fl[i] = f;
  endtask : wr
  // quiet edge that also sets tag and handler state
  task automatic set(logic [7:0] t, logic e);
    @(posedge clk);
    req_valid <= 1'b0;
    tlb_wr_en <= 1'b0;
    process_tag <= t;
    exception_handler_active <= e;
  endtask : set
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test
  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // answer watcher: each pulse takes the oldest note
  always @(posedge clk) begin
    exp_s e;
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) check("spare rsp_valid", 32'h1, 32'h0);
      else begin
        e = q.pop_front();
        check("paddr", rsp_paddr, e.paddr);
        check("exc", {29'h0, rsp_exc}, {29'h0, e.exc});
        check("cached", {31'h0, rsp_cached}, {31'h0, e.cached});
        check("direct", {31'h0, rsp_direct}, {31'h0, e.direct});
        check("fault_vpi", {12'h0, rsp_fault_vpi}, {12'h0, e.fvpi});
        if (e.direct) n_direct++;
      end
    end
  end
  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
  initial begin
    {srst, req_valid, req_io_op, user_mode, tlb_wr_en} = 5'h10;
    {exception_handler_active, tlb_wr_global, tlb_wr_cached} = 3'h0;
    {tlb_wr_read, tlb_wr_write, tlb_wr_exec} = 3'h0;
    {req_vaddr, req_access, process_tag, tlb_wr_tag} = '0;
    {tlb_wr_index, tlb_wr_vpi, tlb_wr_pfi} = '0;
    last_fvpi = '0;
    seed = 20148;
    for (int i = 0; i < 16; i++) begin
      m_vpi[i] = 20'hE0000 + i[19:0];
      {m_tag[i], m_g[i], m_pfi[i], m_fl[i]} = '0;
    end
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    check("reset answer", {rsp_valid, rsp_exc, rsp_paddr[27:0]}, 32'h0);
    // reset entries never hit, handler state picks the miss kind
    set(8'h05, 1'b0);
    req(32'h00001ABC, 2'h1, 1'b0, 1'b0);
    req(32'h80001000, 2'h0, 1'b0, 1'b0);
    set(8'h05, 1'b1);
    req(32'h00001ABC, 2'h2, 1'b0, 1'b1);
    $display("test miss done");
    wr(0, 20'h00001, 8'h05, 1'b0, 20'h12345, 4'hC);
    wr(1, 20'h80001, 8'h00, 1'b1, 20'hFFFFF, 4'h3);
    wr(2, 20'h00001, 8'h09, 1'b0, 20'h00ABC, 4'hF);
    set(8'h05, 1'b0);
    // every access kind, both modes, mapped and unmapped pages
    for (int k = 0; k < 24; k++) begin
      va = k % 3 == 0 ? 32'h00001ABC : k % 3 == 1 ? 32'h80001FFF :
        32'h7FFFF000;
      req(va, k[4:3] == 2'h2 ? 2'h3 : {k[0], k[1]}, 1'b0, k[2]);
    end
    req(32'h00001008, 2'h1, 1'b1, 1'b0);
    set(8'h09, 1'b0);
    req(32'h00001004, 2'h1, 1'b0, 1'b1);
    wr(3, 20'h00002, 8'h09, 1'b0, 20'h00042, 4'h4);
    req(32'h00002010, 2'h1, 1'b0, 1'b1);
    $display("test mapped done");
    // bypass partitions, including the kernel alias of a vector
    for (int k = 0; k < 40; k++) begin
      va = k % 5 == 0 ? 32'hE0000010 : k % 5 == 1 ? 32'hC0000123 :
        k % 5 == 2 ? 32'hDFFFFFFF : k % 5 == 3 ? 32'hFFFFFFFF :
        32'hC0000000 | vec_base;
      req(va, k[3:2] == 2'h3 ? 2'h1 : k[3:2], k[3:2] == 2'h3, k[4]);
    end
    $display("test bypass done");
    // random back-to-back traffic, some aimed at loaded pages
    for (int k = 0; k < 300; k++) begin
      va = $random(seed);
      if (va[8]) va[31:12] = m_vpi[va[1:0]];
      if (k == 150) set(8'h05, 1'b1);
      req(va, va[5:4], va[6] && va[4:3] != 2'h0, va[7]);
    end
    set(8'h05, 1'b0);
    repeat (4) @(posedge clk);
    check("direct count", direct_cnt, n_direct);
    check("answers left", q.size(), 32'h0);
    $display("test random done");
    finish_test();
  end
endmodule : test_mmu_address_translation
`default_nettype wire
